/* File: design/alarm_status.sv */
`timescale 1ns/1ns
`include "alarm_consts.svh"
// Function
// - Event bits latch rising conditions; a set bit ignores repeats.
// - Reading the event register returns it, then clears it.
// - Event bits hold until event read or clear-status command.
// - Condition register follows live fault state, no latching.
// - Reading the condition register changes nothing.
// - A vanished fault clears its condition bit one clock later, at the next rising edge.
// - Three summary bits: over-voltage, under-voltage, over-current.
// - Host reads and writes mask selecting events for status summary.
// - Mask is kept in nonvolatile store, reloaded after power up.
// - Values travel as binary-weighted sums of set bits.
// - 32-bit over-current vector, channel 1 bit 0, channel 32 bit 31.
// - 32-bit over-voltage vector, same channel order.
// - 32-bit under-voltage vector, each bit a live channel.
// - Verification flag reads 1 when done, 0 while running.
// - Wiring calibration flag reads 1 when done, 0 while running.
// - Per-channel wiring resistance, 0 to 5 ohm in milliohms, default 0.
// - Remaining test time reported in minutes.
// - Thermistor temperature, resistance and beta stored, range checked.

module alarm_status #(
  parameter int CHANNELS = `ALM_CHAN_W
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // Live faults and progress
  input  wire logic [CHANNELS-1:0]    ocp_fault_i,
  input  wire logic [CHANNELS-1:0]    ovp_fault_i,
  input  wire logic [CHANNELS-1:0]    uvp_fault_i,
  input  wire logic                   verif_done_i,
  input  wire logic                   wirecal_done_i,
  input  wire logic [`TTIM_W-1:0]     remaining_min_i,
  // Nonvolatile mask store
  input  wire logic [`ALM_REG_W-1:0]  nv_mask_i,
  output logic                        nv_mask_wr_o,
  output logic [`ALM_REG_W-1:0]       nv_mask_data_o,
  // Host command port
  input  wire logic                   cmd_valid_i,
  input  wire alarm_pkg::cmd_op_t     cmd_op_i,
  input  wire logic [4:0]             cmd_index_i,
  input  wire logic [31:0]            cmd_data_i,
  output logic                        rsp_valid_o,
  output logic [31:0]                 rsp_data_o,
  output logic                        rsp_err_o,
  // Status byte summary
  output logic                        alarm_summary_o
);

  logic [CHANNELS-1:0]   ocv_w;
  logic [CHANNELS-1:0]   ovv_w;
  logic [CHANNELS-1:0]   uvv_w;
  logic                  ocp_sum_w;
  logic                  ovp_sum_w;
  logic                  uvp_sum_w;
  logic [`ALM_REG_W-1:0] cond_w;
  logic [`ALM_REG_W-1:0] cond_prev_ff;
  logic [`ALM_REG_W-1:0] rise_w;
  logic [`ALM_REG_W-1:0] event_ff;
  logic [`ALM_REG_W-1:0] nxt_event;
  logic [`ALM_REG_W-1:0] mask_ff;
  logic                  mask_load_ff;
  logic                  verif_done_ff;
  logic                  wirecal_done_ff;
  logic [`TTIM_W-1:0]    ttim_ff;
  logic [`WRES_W-1:0]    wres_ff [CHANNELS];
  logic [31:0]           ther_temp_ff;
  logic [`THER_VAL_W-1:0] ther_res_ff;
  logic [`THER_VAL_W-1:0] ther_beta_ff;
  logic                  summary_ff;
  logic                  nv_wr_ff;
  logic [`ALM_REG_W-1:0] nv_data_ff;
  logic                  rsp_valid_ff;
  logic [31:0]           rsp_data_ff;
  logic                  rsp_err_ff;
  logic [31:0]           nxt_rsp_data;
  logic                  nxt_rsp_err;

  fault_vector_reg #(.WIDTH(CHANNELS)) u_ocp (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .fault_i   (ocp_fault_i),
    .vector_o  (ocv_w),
    .summary_o (ocp_sum_w)
  );

  fault_vector_reg #(.WIDTH(CHANNELS)) u_ovp (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .fault_i   (ovp_fault_i),
    .vector_o  (ovv_w),
    .summary_o (ovp_sum_w)
  );

  fault_vector_reg #(.WIDTH(CHANNELS)) u_uvp (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .fault_i   (uvp_fault_i),
    .vector_o  (uvv_w),
    .summary_o (uvp_sum_w)
  );

  assign cond_w = {{(`ALM_REG_W-3){1'b0}}, ocp_sum_w, uvp_sum_w, ovp_sum_w};
  logic op_rd_event;
  logic op_cls;
  logic op_wr_mask;
  logic op_wr_wres;
  logic op_wr_ther;
  logic wres_ok;
  logic ther_ok;
  logic clr_evt;
  assign op_rd_event = cmd_valid_i && cmd_op_i == alarm_pkg::OP_RD_EVENT;
  assign op_cls      = cmd_valid_i && cmd_op_i == alarm_pkg::OP_CLS;
  assign op_wr_mask  = cmd_valid_i && cmd_op_i == alarm_pkg::OP_WR_MASK;
  assign op_wr_wres  = cmd_valid_i && cmd_op_i == alarm_pkg::OP_WR_WRES;
  assign op_wr_ther  = cmd_valid_i && cmd_op_i == alarm_pkg::OP_WR_THER;
  assign clr_evt     = op_rd_event || op_cls;

  assign wres_ok = cmd_data_i <= `WRES_MAX;
  always_comb begin
    ther_ok = 1'b0;
    if (cmd_index_i == `THER_SEL_TEMP) begin
      ther_ok = $signed(cmd_data_i) >= $signed(`THER_TEMP_MIN) &&
                $signed(cmd_data_i) <= $signed(`THER_TEMP_MAX);
    end else if (cmd_index_i == `THER_SEL_RES ||
                 cmd_index_i == `THER_SEL_BETA) begin
      ther_ok = cmd_data_i >= `THER_VAL_MIN && cmd_data_i <= `THER_VAL_MAX;
    end
  end

  assign rise_w = cond_w & ~cond_prev_ff;
  assign nxt_event = (clr_evt ? `ALM_EVENT_RST : event_ff) | rise_w;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cond_prev_ff <= '0;
      event_ff     <= `ALM_EVENT_RST;
    end else begin
      cond_prev_ff <= cond_w;
      event_ff     <= nxt_event;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_load_ff <= 1'b1;
      mask_ff      <= `ALM_MASK_RST;
      nv_wr_ff     <= 1'b0;
      nv_data_ff   <= `ALM_MASK_RST;
    end else begin
      mask_load_ff <= 1'b0;
      nv_wr_ff     <= op_wr_mask;
      if (op_wr_mask) begin
        mask_ff    <= cmd_data_i[`ALM_REG_W-1:0];
        nv_data_ff <= cmd_data_i[`ALM_REG_W-1:0];
      end else if (mask_load_ff) begin
        mask_ff    <= nv_mask_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      verif_done_ff   <= 1'b0;
      wirecal_done_ff <= 1'b0;
      ttim_ff         <= '0;
    end else begin
      verif_done_ff   <= verif_done_i;
      wirecal_done_ff <= wirecal_done_i;
      ttim_ff         <= remaining_min_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        wres_ff[i] <= `WRES_RST;
      end
    end else if (op_wr_wres && wres_ok) begin
      wres_ff[cmd_index_i] <= cmd_data_i[`WRES_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ther_temp_ff <= `THER_TEMP_RST;
      ther_res_ff  <= `THER_RES_RST;
      ther_beta_ff <= `THER_BETA_RST;
    end else if (op_wr_ther && ther_ok) begin
      if (cmd_index_i == `THER_SEL_TEMP) begin
        ther_temp_ff <= cmd_data_i;
      end
      if (cmd_index_i == `THER_SEL_RES) begin
        ther_res_ff <= cmd_data_i[`THER_VAL_W-1:0];
      end
      if (cmd_index_i == `THER_SEL_BETA) begin
        ther_beta_ff <= cmd_data_i[`THER_VAL_W-1:0];
      end
    end
  end

  always_comb begin
    nxt_rsp_data = 32'h0;
    nxt_rsp_err  = 1'b0;
    unique case (cmd_op_i)
      alarm_pkg::OP_RD_EVENT: nxt_rsp_data = {16'h0, event_ff};
      alarm_pkg::OP_RD_COND:  nxt_rsp_data = {16'h0, cond_w};
      alarm_pkg::OP_RD_MASK:  nxt_rsp_data = {16'h0, mask_ff};
      alarm_pkg::OP_WR_MASK:  nxt_rsp_data = 32'h0;
      alarm_pkg::OP_RD_OCV:   nxt_rsp_data = 32'(ocv_w);
      alarm_pkg::OP_RD_OVV:   nxt_rsp_data = 32'(ovv_w);
      alarm_pkg::OP_RD_UVV:   nxt_rsp_data = 32'(uvv_w);
      alarm_pkg::OP_RD_VERIF: nxt_rsp_data = {31'h0, verif_done_ff};
      alarm_pkg::OP_RD_WCAL:  nxt_rsp_data = {31'h0, wirecal_done_ff};
      alarm_pkg::OP_RD_WRES:  nxt_rsp_data = {19'h0, wres_ff[cmd_index_i]};
      alarm_pkg::OP_WR_WRES:  nxt_rsp_err  = !wres_ok;
      alarm_pkg::OP_RD_TTIM:  nxt_rsp_data = {16'h0, ttim_ff};
      alarm_pkg::OP_RD_THER: begin
        if (cmd_index_i == `THER_SEL_TEMP) begin
          nxt_rsp_data = ther_temp_ff;
        end else if (cmd_index_i == `THER_SEL_RES) begin
          nxt_rsp_data = {12'h0, ther_res_ff};
        end else if (cmd_index_i == `THER_SEL_BETA) begin
          nxt_rsp_data = {12'h0, ther_beta_ff};
        end else begin
          nxt_rsp_err = 1'b1;
        end
      end
      alarm_pkg::OP_WR_THER:  nxt_rsp_err  = !ther_ok;
      alarm_pkg::OP_CLS:      nxt_rsp_data = 32'h0;
      default:                nxt_rsp_err  = 1'b1;
    endcase
  end

  // Response and summary registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 32'h0;
      rsp_err_ff   <= 1'b0;
      summary_ff   <= 1'b0;
    end else begin
      rsp_valid_ff <= cmd_valid_i;
      rsp_data_ff  <= cmd_valid_i ? nxt_rsp_data : 32'h0;
      rsp_err_ff   <= cmd_valid_i && nxt_rsp_err;
      summary_ff   <= |(event_ff & mask_ff);
    end
  end

  assign rsp_valid_o     = rsp_valid_ff;
  assign rsp_data_o      = rsp_data_ff;
  assign rsp_err_o       = rsp_err_ff;
  assign alarm_summary_o = summary_ff;
  assign nv_mask_wr_o    = nv_wr_ff;
  assign nv_mask_data_o  = nv_data_ff;

  property p_evt_hold;
    @(posedge clk_i) disable iff (reset_i)
      !clr_evt |=> (event_ff & $past(event_ff)) == $past(event_ff);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event bit lost");

  property p_rd_clear;
    @(posedge clk_i) disable iff (reset_i)
      op_rd_event |=> event_ff == $past(rise_w) && rsp_valid_o &&
                      rsp_data_o == {16'h0, $past(event_ff)};
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read clear bad");

  property p_evt_latch;
    @(posedge clk_i) disable iff (reset_i)
      cond_w[`ALM_BIT_OCP] && !cond_prev_ff[`ALM_BIT_OCP]
        |=> event_ff[`ALM_BIT_OCP];
  endproperty
  a_evt_latch: assert property (p_evt_latch) else $error("event missed");

  property p_cond_live;
    @(posedge clk_i) disable iff (reset_i)
      ##1 cond_w[`ALM_BIT_UVP] == |$past(uvp_fault_i);
  endproperty
  a_cond_live: assert property (p_cond_live) else $error("cond stale");

  property p_cond_rd;
    @(posedge clk_i) disable iff (reset_i)
      cmd_valid_i && cmd_op_i == alarm_pkg::OP_RD_COND && !clr_evt
        |=> event_ff == ($past(event_ff) | $past(rise_w)) &&
            rsp_data_o == {16'h0, $past(cond_w)};
  endproperty
  a_cond_rd: assert property (p_cond_rd) else $error("cond read bad");

  property p_mask_wr;
    @(posedge clk_i) disable iff (reset_i)
      op_wr_mask |=> mask_ff == $past(cmd_data_i[15:0]) && nv_mask_wr_o &&
                     nv_mask_data_o == $past(cmd_data_i[15:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write bad");

  property p_summary;
    @(posedge clk_i) disable iff (reset_i)
      ##1 alarm_summary_o == |($past(event_ff) & $past(mask_ff));
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");

  property p_wres_rng;
    @(posedge clk_i) disable iff (reset_i)
      op_wr_wres && cmd_data_i > `WRES_MAX |=> rsp_err_o;
  endproperty
  a_wres_rng: assert property (p_wres_rng) else $error("range missed");

  property p_verif;
    @(posedge clk_i) disable iff (reset_i)
      cmd_valid_i && cmd_op_i == alarm_pkg::OP_RD_VERIF
        |=> rsp_data_o == {31'h0, $past(verif_done_ff)};
  endproperty
  a_verif: assert property (p_verif) else $error("verif flag bad");
endmodule // alarm_status

/* File: design/alarm_consts.svh */
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH

// Alarm group widths and bit positions
`define ALM_REG_W        16
`define ALM_CHAN_W       32
`define ALM_BIT_OVP      0
`define ALM_BIT_UVP      1
`define ALM_BIT_OCP      2

// Reset values
`define ALM_MASK_RST     16'h0000
`define ALM_EVENT_RST    16'h0000
`define WRES_RST         13'h0000
`define THER_TEMP_RST    32'h000009c4
`define THER_RES_RST     20'h02710
`define THER_BETA_RST    20'h00fe9

// Value widths and limits
`define WRES_W           13
`define WRES_MAX         32'h00001388
`define THER_TEMP_MIN    32'hffff95b1
`define THER_TEMP_MAX    32'h00006ab3
`define THER_VAL_W       20
`define THER_VAL_MIN     32'h00000001
`define THER_VAL_MAX     32'h000f4240
`define TTIM_W           16

// Thermistor field selects on the index input
`define THER_SEL_TEMP    5'h00
`define THER_SEL_RES     5'h01
`define THER_SEL_BETA    5'h02

`endif

/* File: design/alarm_pkg.sv */
package alarm_pkg;

  typedef enum logic [3:0] {
    OP_RD_EVENT = 4'h0,
    OP_RD_COND  = 4'h1,
    OP_RD_MASK  = 4'h2,
    OP_WR_MASK  = 4'h3,
    OP_RD_OCV   = 4'h4,
    OP_RD_OVV   = 4'h5,
    OP_RD_UVV   = 4'h6,
    OP_RD_VERIF = 4'h7,
    OP_RD_WCAL  = 4'h8,
    OP_RD_WRES  = 4'h9,
    OP_WR_WRES  = 4'ha,
    OP_RD_TTIM  = 4'hb,
    OP_RD_THER  = 4'hc,
    OP_WR_THER  = 4'hd,
    OP_CLS      = 4'he
  } cmd_op_t;

endpackage

/* File: design/fault_vector_reg.sv */
`timescale 1ns/1ns
`include "alarm_consts.svh"

module fault_vector_reg #(
  parameter int WIDTH = `ALM_CHAN_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Live per-channel faults
  input  wire logic [WIDTH-1:0] fault_i,
  // Vector and summary
  output logic      [WIDTH-1:0] vector_o,
  output logic                  summary_o
);

  logic [WIDTH-1:0] vector_ff;
  logic             summary_ff;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      vector_ff  <= '0;
      summary_ff <= 1'b0;
    end else begin
      vector_ff  <= fault_i;
      summary_ff <= |fault_i;
    end
  end

  assign vector_o  = vector_ff;
  assign summary_o = summary_ff;

  property p_sum_or;
    @(posedge clk_i) disable iff (reset_i)
      summary_ff == |vector_ff;
  endproperty
  a_sum_or: assert property (p_sum_or) else $error("summary not OR");

  property p_vec_live;
    @(posedge clk_i) disable iff (reset_i)
      ##1 vector_ff == $past(fault_i);
  endproperty
  a_vec_live: assert property (p_vec_live) else $error("vector stale");

endmodule // fault_vector_reg

/* File: testbench/nv_mask_store.sv */
`timescale 1ns/1ns
module nv_mask_store #(
  parameter logic [15:0] INIT = 16'h0005
) (
  // Store port
  input  wire logic        clk_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] mask_o
);
  logic [15:0] mask_ff = INIT;

  always @(posedge clk_i) begin
    if (wr_i) begin
      mask_ff <= data_i;
    end
  end
  assign mask_o = mask_ff;
endmodule // nv_mask_store

/* File: testbench/alarm_status_tb.sv */
`timescale 1ns/1ns
`include "alarm_consts.svh"
module alarm_status_tb;
  logic               clk_i;
  logic               reset_i;
  logic [31:0]        ocp;
  logic [31:0]        ovp;
  logic [31:0]        uvp;
  logic               verif;
  logic               wcal;
  logic [15:0]        rem;
  logic [15:0]        nv_mask;
  logic [15:0]        nv_data;
  logic               nv_wr;
  logic               cmd_valid;
  alarm_pkg::cmd_op_t cmd_op;
  logic [4:0]         cmd_index;
  logic [31:0]        cmd_data;
  logic               rsp_valid;
  logic [31:0]        rsp_data;
  logic               rsp_err;
  logic               summary;
  logic [31:0]        rd;
  logic [31:0]        v;
  logic [15:0]        w;
  logic [4:0]         ch;
  logic               er;
  int                 err_count;
  int                 checked;
  int                 cycles;

  alarm_status i_dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .ocp_fault_i(ocp), .ovp_fault_i(ovp), .uvp_fault_i(uvp),
    .verif_done_i(verif), .wirecal_done_i(wcal), .remaining_min_i(rem),
    .nv_mask_i(nv_mask), .nv_mask_wr_o(nv_wr), .nv_mask_data_o(nv_data),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_index_i(cmd_index),
    .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .rsp_err_o(rsp_err), .alarm_summary_o(summary)
  );

  nv_mask_store i_nv (
    .clk_i(clk_i), .wr_i(nv_wr), .data_i(nv_data), .mask_o(nv_mask)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One command, answer sampled one edge later
  task automatic cmd(input alarm_pkg::cmd_op_t op, input logic [4:0] idx,
                     input logic [31:0] data);
    @(negedge clk_i);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_index = idx;
    cmd_data  = data;
    @(posedge clk_i);
    #1;
    rd = rsp_data;
    er = rsp_err;
    check({31'h0, rsp_valid}, 32'h1);
    @(negedge clk_i);
    cmd_valid = 1'b0;
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    reset_i = 1'b1;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
  endtask

  task automatic set_fault(input int f, input logic [31:0] val);
    @(negedge clk_i);
    case (f)
      0: ovp = val;
      1: uvp = val;
      default: ocp = val;
    endcase
    repeat (3) @(negedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    reset_i = 1'b1;
    {ocp, ovp, uvp} = '0;
    {verif, wcal, cmd_valid} = '0;
    rem = 16'h0000;
    cmd_op = alarm_pkg::OP_RD_EVENT;
    cmd_index = 5'h00;
    cmd_data = 32'h0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(87652));
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    cmd(alarm_pkg::OP_RD_MASK, 5'h00, 32'h0);
    check(rd, 32'h5); // mask from store
    w = 16'($urandom());
    cmd(alarm_pkg::OP_WR_MASK, 5'h00, {16'h0, w});
    cmd(alarm_pkg::OP_RD_MASK, 5'h00, 32'h0);
    check(rd, {16'h0, w}); // mask read back
    do_reset();
    cmd(alarm_pkg::OP_RD_MASK, 5'h00, 32'h0);
    check(rd, {16'h0, w}); // restored after reset
    for (int f = 0; f < 3; f++) begin
      w = (f == 1) ? 16'h0000 : 16'h0007;
      cmd(alarm_pkg::OP_WR_MASK, 5'h00, {16'h0, w});
      cmd(alarm_pkg::OP_RD_EVENT, 5'h00, 32'h0);
      v = 32'h1 << $urandom_range(31);
      if (f == 2) v = 32'h8000_0001;
      set_fault(f, v);
      cmd(alarm_pkg::cmd_op_t'(4'h5 - 4'(f == 2) + 4'(f == 1)), 5'h00,
          32'h0);
      check(rd, v); // channel vector
      cmd(alarm_pkg::OP_RD_COND, 5'h00, 32'h0);
      check(rd, 32'h1 << f); // summary bit
      cmd(alarm_pkg::OP_RD_COND, 5'h00, 32'h0);
      check(rd, 32'h1 << f); // read leaves it
      check({31'h0, summary}, {31'h0, w[f]}); // masked summary
      cmd(alarm_pkg::OP_RD_EVENT, 5'h00, 32'h0);
      check(rd, 32'h1 << f); // event latched
      cmd(alarm_pkg::OP_RD_EVENT, 5'h00, 32'h0);
      check(rd, 32'h0); // cleared by read
      set_fault(f, 32'h0);
      cmd(alarm_pkg::OP_RD_COND, 5'h00, 32'h0);
      check(rd, 32'h0); // fault gone
      set_fault(f, v);
      cmd(alarm_pkg::OP_CLS, 5'h00, 32'h0);
      repeat (2) @(negedge clk_i);
      check({31'h0, summary}, 32'h0); // nothing pending
      cmd(alarm_pkg::OP_RD_EVENT, 5'h00, 32'h0);
      check(rd, 32'h0); // clear-status
      set_fault(f, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      {wcal, verif} = 2'(i);
      rem = 16'($urandom());
      cmd(alarm_pkg::OP_RD_VERIF, 5'h00, 32'h0);
      check(rd, {31'h0, verif}); // verify flag
      cmd(alarm_pkg::OP_RD_WCAL, 5'h00, 32'h0);
      check(rd, {31'h0, wcal}); // calibration flag
      cmd(alarm_pkg::OP_RD_TTIM, 5'h00, 32'h0);
      check(rd, {16'h0, rem}); // minutes left
    end
    cmd(alarm_pkg::OP_RD_WRES, 5'h1f, 32'h0);
    check(rd, 32'h0); // default zero
    for (int i = 0; i < 4; i++) begin
      ch = 5'($urandom_range(31));
      v = (i == 0) ? 32'd5000 : 32'($urandom_range(5000));
      cmd(alarm_pkg::OP_WR_WRES, ch, v);
      check({31'h0, er}, 32'h0); // legal value
      cmd(alarm_pkg::OP_WR_WRES, ch, 32'd5001);
      check({31'h0, er}, 32'h1); // above 5 ohm
      cmd(alarm_pkg::OP_RD_WRES, ch, 32'h0);
      check(rd, v); // value in force
    end
    cmd(alarm_pkg::OP_RD_THER, 5'h00, 32'h0);
    check(rd, `THER_TEMP_RST); // default temperature
    cmd(alarm_pkg::OP_RD_THER, 5'h01, 32'h0);
    check(rd, {12'h0, `THER_RES_RST}); // default resistance
    cmd(alarm_pkg::OP_WR_THER, 5'h02, 32'd1000000);
    check({31'h0, er}, 32'h0); // beta at upper bound
    cmd(alarm_pkg::OP_WR_THER, 5'h02, 32'd0);
    check({31'h0, er}, 32'h1); // beta below range
    cmd(alarm_pkg::OP_WR_THER, 5'h00, `THER_TEMP_MIN);
    check({31'h0, er}, 32'h0); // lowest temperature legal
    cmd(alarm_pkg::OP_WR_THER, 5'h03, 32'h1);
    check({31'h0, er}, 32'h1); // no such field
    cmd(alarm_pkg::OP_RD_THER, 5'h02, 32'h0);
    check(rd, 32'd1000000); // beta upper bound
    cmd(alarm_pkg::OP_RD_THER, 5'h00, 32'h0);
    check(rd, `THER_TEMP_MIN); // lowest temperature
    cmd(alarm_pkg::cmd_op_t'(4'hf), 5'h00, 32'h0);
    check({31'h0, er}, 32'h1);
    test_done();
  end
endmodule // alarm_status_tb
